// File: verilog/tmc_timer.sv
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "tmc_consts.svh"

// Summary of operation
// - a two-bit mode field picks no mode, event counting, internal timer or pulse width capture.
// - a three-bit ratio field divides the prescaler input by 1, 2, 4 up to 128.
// - the clock select bit takes the system clock when clear and the low-speed crystal when set.
// - the prescaler input clock is shared with the other timer and the pwm block.
// - while pwm is enabled the prescaler input is forced to the system clock.
// - the count enable bit stops the counter when clear and lets it run when set.
// - in event mode the counter steps on rising pin edges with edge select 0, falling with 1.
// - in capture mode edge select 0 counts falling to rising, 1 counts rising to falling.
// - on overflow an interrupt is raised, the counter reloads from preload and keeps counting.
// - in capture mode the enable bit clears when the pin returns, further edges are then ignored.
// - in capture mode setting enable only arms; counting starts at the first active edge.
module tmc_timer (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // external pins and clocks
    input wire logic timer_event_pin_i,
    input wire logic low_speed_crystal_clock_i,
    // shared clock outputs
    output logic prescaler_input_clock_o,
    output logic timer_tick_o,
    // interrupt
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    tmc_pkg::tmc_ctrl_t ctrl_reg;
    logic [7:0] preload_reg;
    logic [7:0] count_reg;
    logic [`TMC_ST_W-1:0] status_reg;
    logic [`TMC_ST_W-1:0] mask_reg;
    logic pwm_en_reg;
    tmc_pkg::tmc_pw_state_t pw_state_reg;
    logic pin_prev_reg;
    logic lxt_prev_reg;
    logic lxt_tick;
    logic psc_input_tick;
    logic psc_tick;
    logic rise;
    logic fall;
    logic start_edge;
    logic stop_edge;
    logic step;
    logic overflow;
    logic pw_done;
    logic wr_en;
    logic rd_en;
    tmc_pkg::tmc_rd_t rd;

    function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
        hit = (addr == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin edges and the low-speed clock edge, all sampled on clock_i

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pin_prev_reg <= 1'b0;
            lxt_prev_reg <= 1'b0;
        end else begin
            pin_prev_reg <= timer_event_pin_i;
            lxt_prev_reg <= low_speed_crystal_clock_i;
        end
    end

    assign rise = timer_event_pin_i && !pin_prev_reg;
    assign fall = !timer_event_pin_i && pin_prev_reg;
    assign lxt_tick = low_speed_crystal_clock_i && !lxt_prev_reg;

    ////////////////////////////////////////////////////////////////////////
    // shared prescaler, its input tick leaves the block for the other users

    tmc_prescaler #(
        .RATIO_W(3)
    ) u_prescaler (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .src_sel_i(ctrl_reg.prescaler_clock_select),
        .pwm_en_i(pwm_en_reg),
        .low_speed_tick_i(lxt_tick),
        .ratio_i(ctrl_reg.prescaler_ratio_field),
        .input_tick_o(psc_input_tick),
        .tick_o(psc_tick)
    );

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            prescaler_input_clock_o <= 1'b0;
            timer_tick_o <= 1'b0;
        end else begin
            prescaler_input_clock_o <= psc_input_tick;
            timer_tick_o <= psc_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // count step selection

    // capture start/stop edges follow the edge select bit
    assign start_edge = ctrl_reg.active_edge_select ? rise : fall;
    assign stop_edge = ctrl_reg.active_edge_select ? fall : rise;

    always_comb begin
        step = 1'b0;
        pw_done = 1'b0;
        case (ctrl_reg.operating_mode_field)
            tmc_pkg::TMC_MODE_EVENT: begin
                // pin is not prescaled in event mode
                step = ctrl_reg.count_enable_bit && (ctrl_reg.active_edge_select ? fall : rise);
            end
            tmc_pkg::TMC_MODE_TIMER: begin
                step = ctrl_reg.count_enable_bit && psc_tick;
            end
            tmc_pkg::TMC_MODE_PULSE: begin
                // the start edge cycle already belongs to the pulse, else the width reads one short
                step = (((pw_state_reg == tmc_pkg::TMC_PW_MEASURE) && !stop_edge)
                        || ((pw_state_reg == tmc_pkg::TMC_PW_ARMED) && start_edge)) && psc_tick;
                pw_done = (pw_state_reg == tmc_pkg::TMC_PW_MEASURE) && stop_edge;
            end
            default: begin
                step = 1'b0; // idle, pin ignored
            end
        endcase
    end

    assign overflow = step && (count_reg == 8'hff);

    ////////////////////////////////////////////////////////////////////////
    // pulse width capture sequencing

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pw_state_reg <= tmc_pkg::TMC_PW_IDLE;
        end else if (ctrl_reg.operating_mode_field != tmc_pkg::TMC_MODE_PULSE
                     || !ctrl_reg.count_enable_bit) begin
            pw_state_reg <= tmc_pkg::TMC_PW_IDLE;
        end else begin
            case (pw_state_reg)
                tmc_pkg::TMC_PW_IDLE: begin
                    pw_state_reg <= tmc_pkg::TMC_PW_ARMED; // enable only arms
                end
                tmc_pkg::TMC_PW_ARMED: begin
                    if (start_edge) begin
                        pw_state_reg <= tmc_pkg::TMC_PW_MEASURE;
                    end
                end
                tmc_pkg::TMC_PW_MEASURE: begin
                    if (stop_edge) begin
                        pw_state_reg <= tmc_pkg::TMC_PW_IDLE;
                    end
                end
                default: begin
                    pw_state_reg <= tmc_pkg::TMC_PW_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb decode, zero wait states

    assign wr_en = psel_i && penable_i && pwrite_i;
    assign rd_en = psel_i && !penable_i && !pwrite_i;

    always_comb begin
        rd.paddr_ok = 1'b1;
        rd.rdata = 32'h0000_0000;
        if (hit(paddr_i, `TMC_CTRL_OFS)) begin
            rd.rdata = {24'h00_0000, ctrl_reg};
        end else if (hit(paddr_i, `TMC_PRELOAD_OFS)) begin
            rd.rdata = {24'h00_0000, preload_reg};
        end else if (hit(paddr_i, `TMC_COUNT_OFS)) begin
            rd.rdata = {24'h00_0000, count_reg};
        end else if (hit(paddr_i, `TMC_STATUS_OFS)) begin
            rd.rdata = {30'h0000_0000, status_reg};
        end else if (hit(paddr_i, `TMC_MASK_OFS)) begin
            rd.rdata = {30'h0000_0000, mask_reg};
        end else if (hit(paddr_i, `TMC_SHARED_OFS)) begin
            rd.rdata = {31'h0000_0000, pwm_en_reg};
        end else begin
            rd.paddr_ok = 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !rd.paddr_ok;
            if (rd_en) begin
                prdata_o <= rd.rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register; hardware clear of enable in capture mode

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_reg <= `TMC_CTRL_RST;
        end else begin
            if (wr_en && hit(paddr_i, `TMC_CTRL_OFS)) begin
                ctrl_reg <= pwdata_i[7:0];
            end
            // auto-clear follows the write so a finished pulse is not re-armed by a stale write
            if (pw_done) begin
                ctrl_reg.count_enable_bit <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            preload_reg <= `TMC_PRELOAD_RST;
            pwm_en_reg <= 1'b0;
            mask_reg <= '0;
        end else if (wr_en) begin
            if (hit(paddr_i, `TMC_PRELOAD_OFS)) begin
                preload_reg <= pwdata_i[7:0];
            end else if (hit(paddr_i, `TMC_SHARED_OFS)) begin
                pwm_en_reg <= pwdata_i[`TMC_SH_PWM_BIT];
            end else if (hit(paddr_i, `TMC_MASK_OFS)) begin
                mask_reg <= pwdata_i[`TMC_ST_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counter: writing the count register loads the counter only, preload keeps its value

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            count_reg <= 8'h00;
        end else if (wr_en && hit(paddr_i, `TMC_COUNT_OFS)) begin
            count_reg <= pwdata_i[7:0];
        end else if (overflow) begin
            count_reg <= preload_reg; // reload and carry on
        end else if (step) begin
            count_reg <= count_reg + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status: write one to clear, a new event wins

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            status_reg <= '0;
            irq_o <= 1'b0;
        end else begin
            for (int i = 0; i < `TMC_ST_W; i++) begin
                if (wr_en && hit(paddr_i, `TMC_STATUS_OFS) && pwdata_i[i]) begin
                    status_reg[i] <= 1'b0;
                end
            end
            if (overflow) begin
                status_reg[`TMC_ST_OVF] <= 1'b1;
            end
            if (pw_done) begin
                status_reg[`TMC_ST_DONE] <= 1'b1;
            end
            irq_o <= |(status_reg & mask_reg);
        end
    end

endmodule // tmc_timer

`default_nettype wire

// File: common/tmc_consts.svh
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH

// register byte offsets
`define TMC_CTRL_OFS 12'h000
`define TMC_PRELOAD_OFS 12'h004
`define TMC_COUNT_OFS 12'h008
`define TMC_STATUS_OFS 12'h00c
`define TMC_MASK_OFS 12'h010
`define TMC_SHARED_OFS 12'h014

// control field positions
`define TMC_MODE_HI 7
`define TMC_MODE_LO 6
`define TMC_SRC_BIT 5
`define TMC_EN_BIT 4
`define TMC_EDGE_BIT 3
`define TMC_PSC_HI 2
`define TMC_PSC_LO 0

// reset values
`define TMC_CTRL_RST 8'h08
`define TMC_PRELOAD_RST 8'h00

// status / mask bits
`define TMC_ST_OVF 0
`define TMC_ST_DONE 1
`define TMC_ST_W 2

// shared clock register bits
`define TMC_SH_PWM_BIT 0

`endif

// File: common/tmc_pkg.sv
package tmc_pkg;

    typedef enum logic [1:0] {
        TMC_MODE_NONE = 2'b00,
        TMC_MODE_EVENT = 2'b01,
        TMC_MODE_TIMER = 2'b10,
        TMC_MODE_PULSE = 2'b11
    } tmc_mode_t;

    typedef struct packed {
        tmc_mode_t operating_mode_field;
        logic prescaler_clock_select;
        logic count_enable_bit;
        logic active_edge_select;
        logic [2:0] prescaler_ratio_field;
    } tmc_ctrl_t;

    typedef struct packed {
        logic paddr_ok;
        logic [31:0] rdata;
    } tmc_rd_t;

    typedef enum {
        TMC_PW_IDLE,
        TMC_PW_ARMED,
        TMC_PW_MEASURE
    } tmc_pw_state_t;

endpackage

// File: verilog/tmc_prescaler.sv
`timescale 1ns/1ns
`default_nettype none

// shared prescaler: picks the input tick, then divides by 2**ratio
module tmc_prescaler #(
    parameter int RATIO_W = 3
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // selection
    input wire logic src_sel_i,
    input wire logic pwm_en_i,
    input wire logic low_speed_tick_i,
    input wire logic [RATIO_W-1:0] ratio_i,
    // outputs
    output logic input_tick_o,
    output logic tick_o
);

    localparam int DIV_W = (1 << RATIO_W) - 1;

    logic [DIV_W-1:0] div_reg;
    logic sel_tick;
    logic [DIV_W:0] mask;

    // pwm forces the system clock regardless of the selector
    assign sel_tick = (src_sel_i && !pwm_en_i) ? low_speed_tick_i : 1'b1;
    assign input_tick_o = sel_tick;
    assign mask = {{DIV_W{1'b0}}, 1'b1} << ratio_i;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            div_reg <= '0;
        end else if (sel_tick) begin
            div_reg <= div_reg + 1'b1;
        end
    end

    // tick when the low ratio bits of the divider are all ones
    always_comb begin
        tick_o = sel_tick && ((({1'b0, div_reg} | ~(mask - 1'b1)) & {1'b0, {DIV_W{1'b1}}})
                              == {1'b0, {DIV_W{1'b1}}} || ratio_i == '0);
    end

endmodule // tmc_prescaler

`default_nettype wire

// File: tb/tmc_timer_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module tmc_timer_asserts (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // pins and outputs
    input wire logic low_speed_crystal_clock_i,
    input wire logic prescaler_input_clock_o,
    input wire logic timer_tick_o,
    input wire logic irq_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    logic src_q;
    logic pwm_q;
    logic sys_sel;
    logic wr_ok;
    logic [2:0] ratio_q;
    logic [3:0] c_sys, c_quiet, c_r0, c_r1;
    function automatic logic [3:0] sat(input logic c, input logic [3:0] v);
        return c ? ((v == 4'hf) ? v : v + 4'h1) : 4'h0;
    endfunction
    assign wr_ok = psel_i && penable_i && pwrite_i && pready_o;
    assign sys_sel = !src_q || pwm_q;
    ////////////////////////////////////////////////////////////////
    // shadow of the clock fields; enable is skipped since capture clears it
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            src_q <= 1'b0;
            ratio_q <= 3'h0;
        end else if (wr_ok && paddr_i == 12'h000) begin
            src_q <= pwdata_i[5];
            ratio_q <= pwdata_i[2:0];
        end
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pwm_q <= 1'b0;
        end else if (wr_ok && paddr_i == 12'h014) begin
            pwm_q <= pwdata_i[0];
        end
    end
    // settle counters hide the pipeline lag after each change
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            c_sys <= 4'h0;
            c_quiet <= 4'h0;
            c_r0 <= 4'h0;
            c_r1 <= 4'h0;
        end else begin
            c_sys <= sat(sys_sel, c_sys);
            c_quiet <= sat(!sys_sel && !low_speed_crystal_clock_i, c_quiet);
            c_r0 <= sat(sys_sel && ratio_q == 3'h0, c_r0);
            c_r1 <= sat(sys_sel && ratio_q == 3'h1, c_r1);
        end
    end
    ////////////////////////////////////////////////////////////////
    ready_after_setup_a:
        assert property (psel_i && !penable_i |=> pready_o) else $error("no ready after setup");
    ready_single_a:
        assert property (pready_o |=> !pready_o) else $error("ready held too long");
    err_on_unmapped_a:
        assert property (pready_o |-> pslverr_o == !(paddr_i[1:0] == 2'h0 && paddr_i <= 12'h014))
        else $error("slave error wrong");
    read_upper_zero_a:
        assert property (pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h0) else $error("upper read bits set");
    sys_clock_sel_a:
        assert property (!src_q && c_sys >= 4'h4 |-> prescaler_input_clock_o) else $error("system tick missing");
    pwm_override_a:
        assert property (src_q && pwm_q && c_sys >= 4'h4 |-> prescaler_input_clock_o) else $error("pwm override lost");
    crystal_quiet_a:
        assert property (c_quiet >= 4'h5 |-> !prescaler_input_clock_o) else $error("tick without crystal edge");
    ratio_zero_a:
        assert property (c_r0 >= 4'h6 |-> timer_tick_o) else $error("divide by one lost tick");
    ratio_one_a:
        assert property (c_r1 >= 4'h6 && timer_tick_o |=> !timer_tick_o) else $error("divide by two wrong");
    cover property (wr_ok && paddr_i == 12'h014);
    cover property ($rose(irq_o));
    cover property (pslverr_o);
endmodule // tmc_timer_asserts
`default_nettype wire

// File: tb/tmc_pin_src.sv
`timescale 1ns/1ns
`default_nettype none
// drives the timer pin: one pulse of hold_i cycles away from the idle level
module tmc_pin_src (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // control
    input wire logic go_i,
    input wire logic idle_i,
    input wire logic [7:0] hold_i,
    // pin
    output logic pin_o,
    output logic busy_o
);
    logic [7:0] left_reg;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            left_reg <= 8'h00;
        end else if (go_i && left_reg == 8'h00) begin
            left_reg <= hold_i;
        end else if (left_reg != 8'h00) begin
            left_reg <= left_reg - 8'h01;
        end
    end
    assign busy_o = (left_reg != 8'h00);
    // pin always comes back to its idle level
    assign pin_o = idle_i ^ busy_o;
endmodule // tmc_pin_src
`default_nettype wire

// File: tb/tmc_timer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tmc_timer_tb_top;
    logic clock_i, rst_i, psel, penable, pwrite, xtal, go, idle, pin, busy;
    logic pready, pslverr, in_clk, tick, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, c;
    logic [7:0] hold;
    int n_mismatch, n_compared;
    tmc_timer tmc_timer_i (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .timer_event_pin_i(pin), .low_speed_crystal_clock_i(xtal),
        .prescaler_input_clock_o(in_clk), .timer_tick_o(tick), .irq_o(irq));
    tmc_pin_src tmc_pin_src_i (.clock_i(clock_i), .rst_i(rst_i), .go_i(go), .idle_i(idle),
        .hold_i(hold), .pin_o(pin), .busy_o(busy));
    task automatic summarize;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int i;
        @(posedge clock_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock_i);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clock_i);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            n_mismatch++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse(input logic [7:0] h);
        int i;
        @(posedge clock_i);
        hold <= h;
        go <= 1'b1;
        @(posedge clock_i);
        go <= 1'b0;
        for (i = 0; i < 300; i++) begin
            @(posedge clock_i);
            if (busy === 1'b0) break;
        end
        if (i == 300) begin
            n_mismatch++;
            summarize();
        end
        repeat (4) @(posedge clock_i);
    endtask
    // which=1 counts prescaler input ticks, which=0 prescaled ticks
    task automatic count_ticks(input logic which, input int n);
        c = 32'h0;
        repeat (n) begin
            @(posedge clock_i);
            if ((which ? in_clk : tick) === 1'b1) c++;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    // crystal runs free at one tenth of the system clock
    initial begin
        xtal = 1'b0;
        forever begin
            repeat (5) @(posedge clock_i);
            xtal <= ~xtal;
        end
    end
    initial begin
        logic [7:0] ctl [4];
        int exp_n [4];
        ctl = '{8'h50, 8'h58, 8'h40, 8'h10};
        exp_n = '{3, 3, 0, 0};
        {rst_i, psel, penable, pwrite, go, idle} = 6'b100000;
        paddr = 12'h000;
        pwdata = 32'h0;
        hold = 8'h00;
        n_mismatch = 0;
        n_compared = 0;
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl reset", 32'h08, rd);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        $display("test reset done");
        for (int e = 0; e < 4; e++) begin
            apb(1'b1, 12'h000, {24'h0, ctl[e]});
            apb(1'b1, 12'h008, 32'h0);
            repeat (3) pulse(8'd3);
            apb(1'b0, 12'h008, 32'h0);
            chk("event count", 32'(exp_n[e]), rd);
        end
        $display("test event modes done");
        apb(1'b1, 12'h004, 32'hf0);
        apb(1'b1, 12'h010, 32'h0);
        apb(1'b1, 12'h008, 32'hff);
        apb(1'b1, 12'h000, 32'h50);
        pulse(8'd3);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b0, 12'h00c, 32'h0);
        chk("overflow status", 32'h1, rd);
        apb(1'b0, 12'h008, 32'h0);
        chk("reload value", 32'hf0, rd);
        apb(1'b1, 12'h010, 32'h1);
        repeat (2) @(posedge clock_i);
        chk("irq raised", 32'h1, {31'h0, irq});
        pulse(8'd3);
        apb(1'b0, 12'h008, 32'h0);
        chk("count after reload", 32'hf1, rd);
        apb(1'b1, 12'h00c, 32'h1);
        repeat (2) @(posedge clock_i);
        chk("irq cleared", 32'h0, {31'h0, irq});
        apb(1'b1, 12'h010, 32'h0);
        $display("test overflow done");
        for (int n = 0; n < 8; n++) begin
            apb(1'b1, 12'h000, 32'h90 | 32'(n));
            repeat (4) @(posedge clock_i);
            count_ticks(1'b0, 256);
            chk("prescaled ticks", 32'(256 >> n), c);
        end
        $display("test prescaler done");
        apb(1'b1, 12'h000, 32'ha0);
        repeat (4) @(posedge clock_i);
        count_ticks(1'b1, 200);
        chk("crystal ticks", 32'd20, c);
        apb(1'b1, 12'h014, 32'h1);
        repeat (4) @(posedge clock_i);
        count_ticks(1'b1, 200);
        chk("pwm forced ticks", 32'd200, c);
        apb(1'b1, 12'h014, 32'h0);
        repeat (4) @(posedge clock_i);
        count_ticks(1'b1, 200);
        chk("crystal ticks again", 32'd20, c);
        $display("test clock source done");
        for (int e = 0; e < 2; e++) begin
            apb(1'b1, 12'h000, 32'h0);
            apb(1'b1, 12'h00c, 32'h3);
            idle <= (e == 0);
            apb(1'b1, 12'h008, 32'h0);
            apb(1'b1, 12'h000, 32'hd0 | 32'(e << 3));
            repeat (10) @(posedge clock_i);
            apb(1'b0, 12'h008, 32'h0);
            chk("armed count", 32'h0, rd);
            pulse(8'd20);
            apb(1'b0, 12'h008, 32'h0);
            chk("pulse width", 32'd20, rd);
            apb(1'b0, 12'h000, 32'h0);
            chk("enable cleared", 32'hc0 | 32'(e << 3), rd);
            apb(1'b0, 12'h00c, 32'h0);
            chk("capture done status", 32'h2, rd);
            pulse(8'd20);
            apb(1'b0, 12'h008, 32'h0);
            chk("later pulse ignored", 32'd20, rd);
        end
        $display("test capture done");
        summarize();
    end
endmodule // tmc_timer_tb_top
bind tmc_timer tmc_timer_asserts tmc_timer_asserts_i (.clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .low_speed_crystal_clock_i,
    .prescaler_input_clock_o, .timer_tick_o, .irq_o);
`default_nettype wire
